// file: hdl/scxa_consts.vh
// Constants for the packed complex-number datapath
`ifndef SCXA_CONSTS_VH
`define SCXA_CONSTS_VH
`define SCXA_OPCODE 7'h7B
`define SCXA_OPC_HI 6
`define SCXA_OPC_LO 0
`define SCXA_F5_HI 31
`define SCXA_F5_LO 27
`define SCXA_F_BIT 26
`define SCXA_B25_BIT 25
`define SCXA_RS2_HI 24
`define SCXA_RS2_LO 20
`define SCXA_RS1_HI 19
`define SCXA_RS1_LO 15
`define SCXA_F3_HI 14
`define SCXA_F3_LO 12
`define SCXA_RD_HI 11
`define SCXA_RD_LO 7
`define SCXA_F5_SUBROT 5'h0D
`define SCXA_F5_CONJ 5'h0B
`define SCXA_F5_CMUL 5'h0A
`define SCXA_RS2_CONJ 5'h00
`define SCXA_F3_CONJ 3'h0
`define SCXA_RE_HI 15
`define SCXA_RE_LO 0
`define SCXA_IM_HI 31
`define SCXA_IM_LO 16
`define SCXA_MUL_SHIFT 5'h0F
`define SCXA_LANE_MASK 16'hFFFF
`define SCXA_OP_NONE 5'h01
`define SCXA_OP_SUBROT 5'h02
`define SCXA_OP_CONJ 5'h04
`define SCXA_OP_MULR 5'h08
`define SCXA_OP_MULI 5'h10
`define SCXA_RST_WORD 32'h00000000
`define SCXA_RST_RD 5'h00
`endif

// file: hdl/scxa_lane_mul.v
// Signed 16x16 lane products combined at full precision
`timescale 1ns/1ps
`default_nettype none
module scxa_lane_mul #(
   parameter W = 16
) (
   input wire signed [W-1:0] a_re,
   input wire signed [W-1:0] a_im,
   input wire signed [W-1:0] b_re,
   input wire signed [W-1:0] b_im,
   output wire signed [2*W+1:0] real_sum,
   output wire signed [2*W+1:0] imag_sum
);
   wire signed [2*W-1:0] p_rr;
   wire signed [2*W-1:0] p_ii;
   wire signed [2*W-1:0] p_ri;
   wire signed [2*W-1:0] p_ir;
   // Four products
   assign p_rr = a_re * b_re;
   assign p_ii = a_im * b_im;
   assign p_ri = a_re * b_im;
   assign p_ir = a_im * b_re;
   // Sign-extended sums keep full precision
   assign real_sum = {{2{p_rr[2*W-1]}}, p_rr} - {{2{p_ii[2*W-1]}}, p_ii};
   assign imag_sum = {{2{p_ri[2*W-1]}}, p_ri} + {{2{p_ir[2*W-1]}}, p_ir};
endmodule // scxa_lane_mul
`default_nettype wire

// file: hdl/scxa_top.v
// Packed complex-number execute stage with its own decode
`timescale 1ns/1ps
`default_nettype none
`include "scxa_consts.vh"
// Behaviour
// - Operand is two signed halves: real in bits 15:0, imaginary in 31:16.
// - Half-word lanes only, register operands only, no immediate or scalar forms.
// - No flags raised, no status or control register touched.
// - No carry or overflow; each lane result truncated to 16 bits.
// - Subrotate: low = a.im-b.im, high = b.re-a.re, masked then shifted 0..3.
// - Subrotate decoded by funct5 0x0D, funct3 000/010/100/110 for scalings.
// - Conjugate keeps real, negates imaginary; funct5 0x0B, rs2 zero, funct3 000.
// - Real multiply writes low half with re*re-im*im shifted 15..18, high kept.
// - Imag multiply writes high half with re*im+im*re shifted 15..18, low kept.
// - Real multiply decoded by funct5 0x0A, funct3 000/010/100/110.
// - Imag multiply decoded by funct5 0x0A, funct3 001/011/101/111.
// - Major opcode 0x7B, bit 26 set, bit 25 clear, standard register fields.
module scxa_top (
   core_clk,
   srst,
   instr_valid,
   instr_word,
   rs1_data,
   rs2_data,
   rd_old_data,
   result_valid,
   result_data,
   result_rd,
   illegal_instr,
   flags_raised
);
   input wire core_clk;
   input wire srst;
   input wire instr_valid;
   input wire [31:0] instr_word;
   input wire [31:0] rs1_data;
   input wire [31:0] rs2_data;
   input wire [31:0] rd_old_data;
   output reg result_valid;
   output reg [31:0] result_data;
   output reg [4:0] result_rd;
   output reg illegal_instr;
   output reg flags_raised;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Logical shift of a masked lane by 0..3, keeping the low 16 bits;
   // the lane is an unsigned pattern here, so zeros enter from the top
   function [15:0] lane_scale;
      input [15:0] v;
      input [1:0] sh;
      begin
         lane_scale = (v & `SCXA_LANE_MASK) >> sh;
      end
   endfunction

   // Full-precision sum shifted right by 15..18, low 16 bits kept
   function [15:0] prod_scale;
      input [33:0] s;
      input [1:0] sh;
      reg [33:0] t;
      begin
         t = $signed(s) >>> ({3'h0, sh} + `SCXA_MUL_SHIFT);
         prod_scale = t[15:0];
      end
   endfunction

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire [6:0] f_opc;
   wire [4:0] f_f5;
   wire [2:0] f_f3;
   wire [4:0] f_rs2;
   wire [4:0] f_rd;
   wire f_space;
   reg [4:0] op_sel;
   reg [1:0] scale_sel;
   wire op_taken;
   wire op_refused;

   assign f_opc = instr_word[`SCXA_OPC_HI:`SCXA_OPC_LO];
   assign f_f5 = instr_word[`SCXA_F5_HI:`SCXA_F5_LO];
   assign f_f3 = instr_word[`SCXA_F3_HI:`SCXA_F3_LO];
   assign f_rs2 = instr_word[`SCXA_RS2_HI:`SCXA_RS2_LO];
   assign f_rd = instr_word[`SCXA_RD_HI:`SCXA_RD_LO];
   // Shared major opcode with bit 26 set and bit 25 clear
   assign f_space = (f_opc == `SCXA_OPCODE) && instr_word[`SCXA_F_BIT]
      && !instr_word[`SCXA_B25_BIT];

   // Operation and scaling selection
   always @* begin
      op_sel = `SCXA_OP_NONE;
      scale_sel = f_f3[2:1];
      if (f_space) begin
         case (f_f5)
            `SCXA_F5_SUBROT: begin
               if (!f_f3[0]) begin
                  op_sel = `SCXA_OP_SUBROT;
               end
            end
            `SCXA_F5_CONJ: begin
               if (f_rs2 == `SCXA_RS2_CONJ && f_f3 == `SCXA_F3_CONJ) begin
                  op_sel = `SCXA_OP_CONJ;
               end
            end
            `SCXA_F5_CMUL: begin
               if (f_f3[0]) begin
                  op_sel = `SCXA_OP_MULI;
               end else begin
                  op_sel = `SCXA_OP_MULR;
               end
            end
            default: begin
               op_sel = `SCXA_OP_NONE;
            end
         endcase
      end
   end

   // Accepted and refused instructions of this cycle
   assign op_taken = instr_valid && (op_sel != `SCXA_OP_NONE);
   assign op_refused = instr_valid && (op_sel == `SCXA_OP_NONE);

   // ---------------------------------------------------------------
   // Datapath
   // ---------------------------------------------------------------
   wire signed [15:0] a_re;
   wire signed [15:0] a_im;
   wire signed [15:0] b_re;
   wire signed [15:0] b_im;
   wire signed [33:0] real_sum;
   wire signed [33:0] imag_sum;
   wire [15:0] sub_lo;
   wire [15:0] sub_hi;
   wire [15:0] conj_hi;
   wire [15:0] subr_lo;
   wire [15:0] subr_hi;
   wire [15:0] mulr_lane;
   wire [15:0] muli_lane;
   reg [31:0] res_d;

   // Lane split of the operands
   assign a_re = rs1_data[`SCXA_RE_HI:`SCXA_RE_LO];
   assign a_im = rs1_data[`SCXA_IM_HI:`SCXA_IM_LO];
   assign b_re = rs2_data[`SCXA_RE_HI:`SCXA_RE_LO];
   assign b_im = rs2_data[`SCXA_IM_HI:`SCXA_IM_LO];

   scxa_lane_mul #(
      .W(16)
   ) u_mul (
      .a_re(a_re),
      .a_im(a_im),
      .b_re(b_re),
      .b_im(b_im),
      .real_sum(real_sum),
      .imag_sum(imag_sum)
   );

   // Lane differences wrap with no carry out
   assign sub_lo = a_im - b_im;
   assign sub_hi = b_re - a_re;
   assign conj_hi = 16'h0000 - a_im;

   // Scaled lanes; rotate lanes shift logically, product lanes arithmetically
   // so that a negative product keeps its sign through the scaling
   assign subr_lo = lane_scale(sub_lo, scale_sel);
   assign subr_hi = lane_scale(sub_hi, scale_sel);
   assign mulr_lane = prod_scale(real_sum, scale_sel);
   assign muli_lane = prod_scale(imag_sum, scale_sel);

   // Result selection; multiplies merge the prior destination half
   always @* begin
      res_d = rd_old_data;
      case (op_sel)
         `SCXA_OP_SUBROT: begin
            res_d = {subr_hi, subr_lo};
         end
         `SCXA_OP_CONJ: begin
            res_d = {conj_hi, rs1_data[`SCXA_RE_HI:`SCXA_RE_LO]};
         end
         `SCXA_OP_MULR: begin
            res_d = {rd_old_data[`SCXA_IM_HI:`SCXA_IM_LO], mulr_lane};
         end
         `SCXA_OP_MULI: begin
            res_d = {muli_lane, rd_old_data[`SCXA_RE_HI:`SCXA_RE_LO]};
         end
         default: begin
            res_d = rd_old_data;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Result registers
   // ---------------------------------------------------------------
   // Pulse outputs: one cycle per taken or refused instruction, flags never raised
   always @(posedge core_clk) begin
      if (srst) begin
         result_valid <= 1'b0;
         illegal_instr <= 1'b0;
         flags_raised <= 1'b0;
      end else begin
         result_valid <= op_taken;
         illegal_instr <= op_refused;
         flags_raised <= 1'b0;
      end
   end

   // Held outputs: a refused instruction leaves the last result in place,
   // so a consumer that misses the pulse still reads a coherent value
   always @(posedge core_clk) begin
      if (srst) begin
         result_data <= `SCXA_RST_WORD;
         result_rd <= `SCXA_RST_RD;
      end else if (op_taken) begin
         result_data <= res_d;
         result_rd <= f_rd;
      end
   end
endmodule // scxa_top
`default_nettype wire

// file: sim/scxa_rf_model.sv
// Register-file model that feeds operands to the execute stage
`timescale 1ns/1ps
`default_nettype none
module scxa_rf_model (
   input wire logic core_clk,
   input wire logic ld_en,
   input wire logic [4:0] ld_idx,
   input wire logic [31:0] ld_data,
   input wire logic [31:0] instr_word,
   output logic [31:0] rs1_data,
   output logic [31:0] rs2_data,
   output logic [31:0] rd_old_data
);
   logic [31:0] regs_q [32];
   // Load port fills the file before traffic starts
   always @(posedge core_clk) begin
      if (ld_en) begin
         regs_q[ld_idx] <= ld_data;
      end
   end
   // Reads follow the instruction's register fields at once
   assign rs1_data = regs_q[instr_word[19:15]];
   assign rs2_data = regs_q[instr_word[24:20]];
   assign rd_old_data = regs_q[instr_word[11:7]];
endmodule // scxa_rf_model
`default_nettype wire

// file: sim/scxa_top_sva.sv
// Port checker for the complex-number execute stage
`timescale 1ns/1ps
`default_nettype none
module scxa_top_sva (
   input wire core_clk,
   input wire srst,
   input wire instr_valid,
   input wire [31:0] instr_word,
   input wire [31:0] rs1_data,
   input wire [31:0] rd_old_data,
   input wire result_valid,
   input wire [31:0] result_data,
   input wire [4:0] result_rd,
   input wire illegal_instr,
   input wire flags_raised
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   wire [4:0] f5 = instr_word[31:27];
   a_no_flags: assert property (!flags_raised) else $error("flag raised");
   a_one_answer: assert property (!(result_valid && illegal_instr))
      else $error("two answers");
   a_bad_opcode: assert property (instr_valid && (instr_word[6:0] != 7'h7B
      || !instr_word[26] || instr_word[25]) |=> illegal_instr && !result_valid)
      else $error("bad encoding taken");
   a_dest_index: assert property (result_valid |-> result_rd == $past(instr_word[11:7]))
      else $error("wrong destination");
   a_conj_lanes: assert property (result_valid && $past(f5) == 5'h0B |->
      result_data == {16'h0000 - $past(rs1_data[31:16]), $past(rs1_data[15:0])})
      else $error("conj");
   a_mulr_keep: assert property (result_valid && $past(f5 == 5'h0A && !instr_word[12]) |->
      result_data[31:16] == $past(rd_old_data[31:16])) else $error("high half lost");
   a_muli_keep: assert property (result_valid && $past(f5 == 5'h0A && instr_word[12]) |->
      result_data[15:0] == $past(rd_old_data[15:0])) else $error("low half lost");
   a_subrot_odd: assert property (instr_valid && f5 == 5'h0D && instr_word[12]
      |=> illegal_instr) else $error("odd subrot taken");
endmodule // scxa_top_sva
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the complex-number execute stage
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic instr_valid = 1'b0;
   logic [31:0] instr_word = 32'h00000000;
   logic ld_en = 1'b0;
   logic [4:0] ld_idx = 5'h00;
   logic [31:0] ld_data = 32'h00000000;
   wire [31:0] rs1_data, rs2_data, rd_old_data, result_data;
   wire [4:0] result_rd;
   wire result_valid, illegal_instr, flags_raised;
   logic [31:0] mirror [32];
   logic [4:0] f5_pick [5] = '{5'h0D, 5'h0B, 5'h0A, 5'h0A, 5'h1A};
   logic [38:0] notes [$];
   logic [36:0] last_q = 37'h0000000000;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   always #4 core_clk = ~core_clk;
   scxa_top u_scxa_top (.core_clk, .srst, .instr_valid, .instr_word, .rs1_data, .rs2_data,
      .rd_old_data, .result_valid, .result_data, .result_rd, .illegal_instr, .flags_raised);
   scxa_rf_model u_scxa_rf_model (.core_clk, .ld_en, .ld_idx, .ld_data, .instr_word, .rs1_data,
      .rs2_data, .rd_old_data);
   // Reference result: {valid, illegal, rd, high lane, low lane}
   function automatic logic [38:0] ref_op(input logic [31:0] w, a, b, o);
      logic signed [33:0] m;
      logic [15:0] lo;
      logic [15:0] hi;
      logic ok;
      ok = w[6:0] == 7'h7B && w[26:25] == 2'b10;
      lo = (a[31:16] - b[31:16]) >> w[14:13];
      hi = (b[15:0] - a[15:0]) >> w[14:13];
      case (w[31:27])
         5'h0D: ok = ok && !w[12];
         5'h0B: begin
            ok = ok && w[24:20] == 5'h00 && w[14:12] == 3'h0;
            lo = a[15:0];
            hi = 16'h0000 - a[31:16];
         end
         5'h0A: begin
            m = w[12] ? $signed(a[15:0]) * $signed(b[31:16]) + $signed(a[31:16]) * $signed(b[15:0])
               : $signed(a[15:0]) * $signed(b[15:0]) - $signed(a[31:16]) * $signed(b[31:16]);
            m = m >>> (15 + w[14:13]);
            lo = w[12] ? o[15:0] : m[15:0];
            hi = w[12] ? m[15:0] : o[31:16];
         end
         default: ok = 1'b0;
      endcase
      return {ok, !ok, w[11:7], hi, lo};
   endfunction
   task automatic check(input logic [38:0] seen, input logic [38:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (miscompares == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Each answer is matched against the oldest note; outputs stay idle in reset
   always @(negedge core_clk) begin
      check({38'h0, flags_raised}, 39'h0000000000);
      if (srst) begin
         check({result_valid, illegal_instr, result_rd, result_data}, 39'h0000000000);
      end else if (result_valid || illegal_instr) begin
         check({result_valid, illegal_instr, result_rd, result_data}, notes.pop_front());
      end
   end
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         final_report();
      end
   end
   // Fill registers, then a random stream with idle cycles and broken encodings mixed in
   initial begin
      logic [31:0] w;
      logic [38:0] e;
      logic v;
      void'($urandom(87));
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         w = (i == 1) ? 32'h80008000 : (i == 2) ? 32'h7FFF7FFF : $urandom;
         ld_en <= 1'b1;
         ld_idx <= i[4:0];
         ld_data <= w;
         mirror[i] = w;
         @(posedge core_clk);
      end
      ld_en <= 1'b0;
      for (int n = 0; n < 1500; n++) begin
         w = $urandom;
         w[31:27] = f5_pick[$urandom_range(0, 4)];
         w[6:0] = ($urandom_range(0, 15) == 0) ? w[6:0] : 7'h7B;
         w[26:25] = ($urandom_range(0, 15) == 0) ? w[26:25] : 2'b10;
         if (w[31:27] == 5'h0B && $urandom_range(0, 3) != 0) begin
            w[24:20] = 5'h00;
            w[14:12] = 3'h0;
         end
         v = $urandom_range(0, 4) != 0;
         instr_valid <= v;
         instr_word <= w;
         e = ref_op(w, mirror[w[19:15]], mirror[w[24:20]], mirror[w[11:7]]);
         if (e[37]) begin
            e[36:0] = last_q;
         end else if (v) begin
            last_q = e[36:0]; // Only a taken instruction moves the held result
         end
         if (v) begin
            notes.push_back(e);
         end
         @(posedge core_clk);
      end
      instr_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
      check(39'(notes.size()), 39'h0000000000);
      final_report();
   end
endmodule // tb_top
bind scxa_top scxa_top_sva u_scxa_top_sva (.core_clk, .srst, .instr_valid, .instr_word,
   .rs1_data, .rd_old_data, .result_valid, .result_data, .result_rd, .illegal_instr,
   .flags_raised);
`default_nettype wire
